// File: dv/scs_checker.sv
/*
  Checker on the two-wire link between host end and device end.
  Assumes the host end runs with quarters of at least 8 clk cycles.
*/
`timescale 1ns/1ps
module scs_checker (
  // clocks and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic link_rstn,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  // ----------------------------------------
  // host end, clk domain
  // ----------------------------------------
  a_host_open_drain: assert property (
    @(posedge clk) disable iff (!rstn) !host_sda_oe_n |-> !host_sda_o)
    else $error("host drives sda high");
  a_scl_high_min: assert property (
    @(posedge clk) disable iff (!rstn) $rose(scl) |-> scl [*8])
    else $error("scl high phase short");
  a_scl_low_min: assert property (
    @(posedge clk) disable iff (!rstn) $fell(scl) |-> !scl [*8])
    else $error("scl low phase short");
  a_start_hold: assert property (
    @(posedge clk) disable iff (!rstn) $fell(host_sda_oe_n) && scl |-> (scl && !sda) [*4])
    else $error("start not held");
  a_stop_idle: assert property (
    @(posedge clk) disable iff (!rstn) $rose(host_sda_oe_n) && scl |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  // ----------------------------------------
  // device end, link clock domain
  // ----------------------------------------
  a_dev_open_drain: assert property (
    @(posedge link_clk) disable iff (!link_rstn) !dev_sda_oe_n |-> !dev_sda_o)
    else $error("device drives sda high");
  // data may only move while scl is low, or a start or stop is faked
  a_dev_moves_low: assert property (
    @(posedge link_clk) disable iff (!link_rstn) $changed(dev_sda_oe_n) |-> !scl)
    else $error("device moved sda while scl high");
  a_dev_holds_bit: assert property (
    @(posedge link_clk) disable iff (!link_rstn) $fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
    else $error("device low bit too short");
endmodule

// File: dv/test_smbus_config_slave.sv
/*
  Bench: host end and device end on one link, a second device driven
  bit by bit from the bench.
  Assumes the design files and scs_params.svh compile first.
*/
`timescale 1ns/1ps
`include "scs_params.svh"
module test_smbus_config_slave;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       link_rstn = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_read = 1'b0;
  logic       cmd_block = 1'b0;
  logic [6:0] cmd_offset = 7'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic       cmd_ready, wr_take, rd_valid, done, nack_err;
  logic       out1_enable, out2_enable, out3_enable, out4_enable;
  logic [7:0] oes;
  logic [7:0] wq [0:15];
  logic [7:0] rq [0:15];
  logic [7:0] img [0:11];
  logic [7:0] oe_val [0:3] = '{8'h40, 8'h20, 8'h08, 8'h04};
  int         wi, ri, err_total, comparisons;
  scs_if      bus ();
  scs_if      bus_b ();

  assign oes = {4'h0, out1_enable, out2_enable, out3_enable, out4_enable};
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  scs_host #(.QCYC(8)) i_scs_host (.clk, .rstn, .bus, .cmd_valid, .cmd_ready, .cmd_read, .cmd_block,
    .cmd_offset, .cmd_len, .wr_data, .wr_take, .rd_data, .rd_valid, .done, .nack_err);
  scs_dev i_scs_dev (.link_clk, .link_rstn, .bus, .clk, .rstn, .out1_enable, .out2_enable, .out3_enable,
    .out4_enable);
  // bench plays a rogue host here, so bad addresses reach a device
  scs_dev i_scs_dev_b (.link_clk, .link_rstn, .bus(bus_b), .clk, .rstn, .out1_enable(), .out2_enable(),
    .out3_enable(), .out4_enable());
  scs_checker i_scs_checker (.clk, .rstn, .link_clk, .link_rstn, .scl(bus.scl), .host_sda_o(bus.host_sda_o),
    .host_sda_oe_n(bus.host_sda_oe_n), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n), .sda(bus.sda));

  // ----------------------------------------
  // data feed and capture
  // ----------------------------------------
  always @(posedge clk) begin
    if (wr_take) begin
      wi      <= wi + 1;
      wr_data <= wq[wi + 1];
    end
    if (rd_valid) begin
      rq[ri] <= rd_data;
      ri     <= ri + 1;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic xfer(input logic rd, input logic blk, input logic [6:0] off, input logic [7:0] len);
    int n;
    @(posedge clk);
    cmd_valid  <= 1'b1;
    cmd_read   <= rd;
    cmd_block  <= blk;
    cmd_offset <= off;
    cmd_len    <= len;
    wi         <= 0;
    ri         <= 0;
    wr_data    <= wq[0];
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    chk("ready", {7'h00, cmd_ready}, 8'h00);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    chk("done", {7'h00, done}, 8'h01);
    chk("ready", {7'h00, cmd_ready}, 8'h01);
  endtask

  task automatic rd_all();
    xfer(1'b1, 1'b1, 7'h00, 8'h0C);
    chk("rcount", 8'(ri), 8'h0C);
    for (int i = 0; i < 12; i++) chk("rblock", rq[i], img[i]);
  endtask

  // one quarter bit of the rogue host, eight clk cycles
  task automatic qtr(input logic s, input logic d);
    @(posedge clk);
    bus_b.scl           <= s;
    bus_b.host_sda_oe_n <= d;
    repeat (7) @(posedge clk);
  endtask

  task automatic raw_addr(input logic [7:0] a, input logic ack);
    qtr(1'b1, 1'b0);
    qtr(1'b0, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      qtr(1'b0, a[i]);
      qtr(1'b1, a[i]);
      qtr(1'b1, a[i]);
      qtr(1'b0, a[i]);
    end
    qtr(1'b0, 1'b1);
    qtr(1'b1, 1'b1);
    chk("raw_ack", {7'h00, bus_b.sda}, {7'h00, ack});
    qtr(1'b0, 1'b1);
    qtr(1'b0, 1'b0);
    qtr(1'b1, 1'b0);
    qtr(1'b1, 1'b1);
  endtask

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    #2000000;
    err_total++;
    test_done();
  end

  initial begin
    bus_b.scl           = 1'b1;
    bus_b.host_sda_o    = 1'b0;
    bus_b.host_sda_oe_n = 1'b1;
    for (int i = 0; i < 12; i++) img[i] = 8'(`SCS_REG_DEFAULTS >> (8 * i));
    repeat (10) @(posedge clk);
    link_rstn <= 1'b1;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("idle", {6'h00, bus.scl, bus.sda}, 8'h03);
    chk("enables", oes, 8'h0F);
    rd_all();
    // every write falls in the set-up phase right after reset
    for (int k = 0; k < 4; k++) begin
      wq[0]  = oe_val[k];
      img[4] = oe_val[k];
      xfer(1'b0, 1'b0, 7'h04, 8'h01);
      chk("nack", {7'h00, nack_err}, 8'h00);
      chk("enables", oes, 8'h08 >> k);
    end
    for (int i = 4; i < 12; i += 7) begin
      xfer(1'b1, 1'b0, 7'(i), 8'h01);
      chk("rbyte", rq[0], img[i]);
    end
    wq[0]  = 8'h11;
    wq[1]  = 8'h22;
    wq[2]  = 8'h33;
    img[0] = 8'h11;
    img[1] = 8'h22;
    img[2] = 8'h33;
    xfer(1'b0, 1'b1, 7'h00, 8'h03);
    chk("nack", {7'h00, nack_err}, 8'h00);
    // stop after two bytes must leave the image intact
    xfer(1'b1, 1'b1, 7'h00, 8'h02);
    chk("rcount", 8'(ri), 8'h02);
    chk("rblock", rq[1], 8'h22);
    rd_all();
    raw_addr(8'hD4, 1'b1);
    raw_addr(8'hD2, 1'b0);
    test_done();
  end
endmodule

// File: hw/scs_dev.sv
/*
  Device end of the serial configuration port: slave engine on the link
  clock, register image, and output enables crossed into the user clock.
  Assumes link_clk oversamples scl by a wide margin and the host keeps sda
  steady while scl is high except for start and stop.
*/
// Contract
// - respond only to address 11010010
// - byte and block, read and write supported
// - command bit 7 picks block or byte
// - low command bits give byte offset
// - byte write acked address, command, data
// - byte read: repeated start, one byte, nack
// - block write: count then data, all acked
// - block read returns count then data bytes
// - ascending offsets from lowest, msb first
// - early stop keeps completed bytes intact
// - registers load defaults at power up
// - host changes registers at initialisation only
// - writes enable or disable each output
// - enable bit set means enabled, default one
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_dev (
  // link side
  input  wire logic link_clk,
  input  wire logic link_rstn,
  scs_if.dev        bus,
  // user side
  input  wire logic clk,
  input  wire logic rstn,
  output logic      out1_enable,
  output logic      out2_enable,
  output logic      out3_enable,
  output logic      out4_enable
);

  localparam int                          NBYTES = `SCS_NBYTES;
  localparam logic [6:0]                  NB7    = 7'(NBYTES);
  localparam logic [8*`SCS_NBYTES-1:0]    DEFS   = `SCS_REG_DEFAULTS;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;

  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  logic start_det, stop_det, scl_rise, scl_fall;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;

  // ----------------------------------------
  // slave engine
  // ----------------------------------------
  scs_pkg::scs_dev_st_t st_reg, nxt_st_reg;
  logic [3:0]           bitcnt_reg;
  logic [7:0]           sh_reg;
  logic                 drv_reg;
  logic                 blk_reg;
  logic                 first_reg;
  logic [6:0]           ptr_reg;
  logic [7:0]           rem_reg;
  logic [7:0]           regs [NBYTES];
  logic                 wr_ok;
  logic                 wr_fire;
  logic [7:0]           load_byte;

  // writes past the image or past the count are acked but dropped
  assign wr_ok = (ptr_reg < NB7) && (!blk_reg || rem_reg != 8'h00);
  assign wr_fire = !start_det && !stop_det && st_reg == scs_pkg::DS_WDATA &&
                   scl_fall && bitcnt_reg == 4'h8 && wr_ok;
  always_comb begin
    if (first_reg)
      load_byte = 8'(NBYTES);
    else if (ptr_reg < NB7)
      load_byte = regs[ptr_reg[3:0]];
    else
      load_byte = `SCS_FILL_BYTE;
  end

  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      st_reg     <= scs_pkg::DS_IDLE;
      nxt_st_reg <= scs_pkg::DS_IDLE;
      bitcnt_reg <= 4'h0;
      sh_reg     <= 8'h00;
      drv_reg    <= 1'b0;
      blk_reg    <= 1'b0;
      first_reg  <= 1'b0;
      ptr_reg    <= 7'h00;
      rem_reg    <= 8'h00;
    end else if (start_det) begin
      // command state survives a repeated start
      st_reg     <= scs_pkg::DS_ADDR;
      bitcnt_reg <= 4'h0;
      drv_reg    <= 1'b0;
    end else if (stop_det) begin
      st_reg  <= scs_pkg::DS_IDLE;
      drv_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        scs_pkg::DS_IDLE, scs_pkg::DS_IGNORE: begin
        end
        scs_pkg::DS_ADDR, scs_pkg::DS_CMD, scs_pkg::DS_COUNT, scs_pkg::DS_WDATA: begin
          if (scl_rise && bitcnt_reg != 4'h8) begin
            sh_reg     <= {sh_reg[6:0], sda_s};
            bitcnt_reg <= bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            bitcnt_reg <= 4'h0;
            drv_reg    <= 1'b1;
            st_reg     <= scs_pkg::DS_SACK;
            if (st_reg == scs_pkg::DS_ADDR) begin
              if (sh_reg[7:1] != `SCS_SLAVE_ADDR) begin
                drv_reg <= 1'b0;
                st_reg  <= scs_pkg::DS_IGNORE;
              end
              nxt_st_reg <= sh_reg[0] ? scs_pkg::DS_RDATA : scs_pkg::DS_CMD;
            end else if (st_reg == scs_pkg::DS_CMD) begin
              blk_reg    <= !sh_reg[`SCS_CMD_BYTE_BIT];
              first_reg  <= !sh_reg[`SCS_CMD_BYTE_BIT];
              ptr_reg    <= sh_reg[`SCS_CMD_BYTE_BIT] ? sh_reg[6:0] : `SCS_BLOCK_OFFSET;
              nxt_st_reg <= sh_reg[`SCS_CMD_BYTE_BIT] ? scs_pkg::DS_WDATA : scs_pkg::DS_COUNT;
            end else if (st_reg == scs_pkg::DS_COUNT) begin
              rem_reg    <= sh_reg;
              nxt_st_reg <= scs_pkg::DS_WDATA;
            end else begin
              if (wr_ok)
                ptr_reg <= ptr_reg + 7'h01;
              if (blk_reg && rem_reg != 8'h00)
                rem_reg <= rem_reg - 8'h01;
              nxt_st_reg <= scs_pkg::DS_WDATA;
            end
          end
        end
        scs_pkg::DS_SACK: begin
          if (scl_fall) begin
            drv_reg    <= 1'b0;
            st_reg     <= nxt_st_reg;
            bitcnt_reg <= 4'h0;
            if (nxt_st_reg == scs_pkg::DS_RDATA) begin
              sh_reg  <= load_byte;
              drv_reg <= !load_byte[7];
              if (first_reg)
                first_reg <= 1'b0;
              else
                ptr_reg <= ptr_reg + 7'h01;
            end
          end
        end
        scs_pkg::DS_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_reg == 4'h7) begin
              drv_reg <= 1'b0;
              st_reg  <= scs_pkg::DS_HACK;
            end else begin
              drv_reg    <= !sh_reg[6];
              sh_reg     <= {sh_reg[6:0], 1'b0};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
        end
        scs_pkg::DS_HACK: begin
          if (scl_rise) begin
            // a nack ends the read; only stop or start follows
            st_reg     <= sda_s ? scs_pkg::DS_IGNORE : scs_pkg::DS_SACK;
            nxt_st_reg <= scs_pkg::DS_RDATA;
          end
        end
      endcase
    end
  end

  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = !drv_reg;

  // ----------------------------------------
  // register image
  // ----------------------------------------
  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      for (int i = 0; i < NBYTES; i++) begin
        regs[i] <= DEFS[i*8 +: 8];
      end
    end else if (wr_fire) begin
      regs[ptr_reg[3:0]] <= sh_reg;
    end
  end

  // ----------------------------------------
  // output enables into the user clock
  // ----------------------------------------
  // independent quasi-static levels, so per-bit two-flop crossing suffices
  logic [3:0] oe_m, oe_s;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      oe_m <= 4'hF;
      oe_s <= 4'hF;
    end else begin
      oe_m <= {regs[`SCS_OE_BYTE][`SCS_OE1_BIT], regs[`SCS_OE_BYTE][`SCS_OE2_BIT],
               regs[`SCS_OE_BYTE][`SCS_OE3_BIT], regs[`SCS_OE_BYTE][`SCS_OE4_BIT]};
      oe_s <= oe_m;
    end
  end

  assign out1_enable = oe_s[3];
  assign out2_enable = oe_s[2];
  assign out3_enable = oe_s[1];
  assign out4_enable = oe_s[0];

endmodule

// File: hw/scs_host.sv
/*
  Host end of the serial configuration port: makes scl by a divider and
  runs byte, block, read and write transactions from a command port.
  Assumes the user holds wr_data valid for each byte until wr_take.
*/
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_host #(
  parameter int QCYC = `SCS_QUARTER_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // link
  scs_if.host       bus,
  // command port
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic       cmd_block,
  input  wire logic [6:0] cmd_offset,
  input  wire logic [7:0] cmd_len,
  // data
  input  wire logic [7:0] wr_data,
  output logic            wr_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            nack_err
);

  // ----------------------------------------
  // quarter-bit timer and data sync
  // ----------------------------------------
  scs_pkg::scs_host_st_t hst_reg;
  scs_pkg::scs_stage_t   stage_reg;
  logic [15:0]           qcnt_reg;
  logic [1:0]            q_reg;
  logic                  tick;
  logic                  sda_m, sda_s;

  assign tick = (qcnt_reg == 16'(QCYC - 1));

  always_ff @(posedge clk) begin
    if (!rstn || hst_reg == scs_pkg::HS_IDLE || tick)
      qcnt_reg <= 16'h0000;
    else
      qcnt_reg <= qcnt_reg + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= bus.sda;
      sda_s <= sda_m;
    end
  end

  // ----------------------------------------
  // transaction sequencer
  // ----------------------------------------
  logic [3:0] bitn_reg;
  logic [7:0] sh_reg;
  logic [7:0] rem_reg;
  logic       rd_reg, blk_reg, ack_reg;
  logic [6:0] offset_reg;
  logic       tx, last;

  assign tx   = stage_reg != scs_pkg::SG_RCOUNT && stage_reg != scs_pkg::SG_RDATA;
  assign last = (stage_reg == scs_pkg::SG_RCOUNT) ? (rem_reg == 8'h00) : (rem_reg == 8'h01);
  assign cmd_ready = (hst_reg == scs_pkg::HS_IDLE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hst_reg   <= scs_pkg::HS_IDLE;
      stage_reg <= scs_pkg::SG_ADDRW;
      q_reg     <= 2'h0;
      bitn_reg  <= 4'h0;
      sh_reg    <= 8'h00;
      rem_reg   <= 8'h00;
      rd_reg    <= 1'b0;
      blk_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      wr_take   <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      done      <= 1'b0;
      nack_err  <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (hst_reg == scs_pkg::HS_IDLE) begin
        if (cmd_valid) begin
          hst_reg   <= scs_pkg::HS_START;
          stage_reg <= scs_pkg::SG_ADDRW;
          q_reg     <= 2'h0;
          sh_reg    <= {`SCS_SLAVE_ADDR, 1'b0};
          rd_reg    <= cmd_read;
          blk_reg   <= cmd_block;
          rem_reg   <= cmd_block ? cmd_len : 8'h01;
          nack_err  <= 1'b0;
          ack_reg   <= 1'b0;
          bitn_reg  <= 4'h0;
        end
      end else if (tick) begin
        q_reg <= q_reg + 2'h1;
        unique case (hst_reg)
          scs_pkg::HS_START: begin
            if (q_reg == 2'h3) begin
              hst_reg  <= scs_pkg::HS_BIT;
              bitn_reg <= 4'h0;
            end
          end
          scs_pkg::HS_STOP: begin
            if (q_reg == 2'h3) begin
              hst_reg <= scs_pkg::HS_IDLE;
              done    <= 1'b1;
            end
          end
          scs_pkg::HS_IDLE: begin
          end
          scs_pkg::HS_BIT: begin
            if (q_reg == 2'h2) begin
              if (bitn_reg == 4'h8)
                ack_reg <= sda_s;
              else if (!tx)
                sh_reg <= {sh_reg[6:0], sda_s};
            end else if (q_reg == 2'h3 && bitn_reg != 4'h8) begin
              bitn_reg <= bitn_reg + 4'h1;
              if (tx)
                sh_reg <= {sh_reg[6:0], 1'b0};
            end else if (q_reg == 2'h3) begin
              bitn_reg <= 4'h0;
              if (tx && ack_reg) begin
                nack_err <= 1'b1;
                hst_reg  <= scs_pkg::HS_STOP;
              end else begin
                unique case (stage_reg)
                  scs_pkg::SG_ADDRW: begin
                    stage_reg <= scs_pkg::SG_CMD;
                    sh_reg    <= blk_reg ? {1'b0, `SCS_BLOCK_OFFSET} : {1'b1, offset_reg};
                  end
                  scs_pkg::SG_CMD: begin
                    if (rd_reg) begin
                      stage_reg <= scs_pkg::SG_ADDRR;
                      sh_reg    <= {`SCS_SLAVE_ADDR, 1'b1};
                      hst_reg   <= scs_pkg::HS_START;
                    end else if (blk_reg) begin
                      stage_reg <= scs_pkg::SG_COUNT;
                      sh_reg    <= rem_reg;
                    end else begin
                      stage_reg <= scs_pkg::SG_WDATA;
                      sh_reg    <= wr_data;
                      wr_take   <= 1'b1;
                    end
                  end
                  scs_pkg::SG_COUNT: begin
                    if (rem_reg == 8'h00) begin
                      hst_reg <= scs_pkg::HS_STOP;
                    end else begin
                      stage_reg <= scs_pkg::SG_WDATA;
                      sh_reg    <= wr_data;
                      wr_take   <= 1'b1;
                    end
                  end
                  scs_pkg::SG_WDATA: begin
                    rem_reg <= rem_reg - 8'h01;
                    if (rem_reg == 8'h01) begin
                      hst_reg <= scs_pkg::HS_STOP;
                    end else begin
                      sh_reg  <= wr_data;
                      wr_take <= 1'b1;
                    end
                  end
                  scs_pkg::SG_ADDRR: begin
                    stage_reg <= blk_reg ? scs_pkg::SG_RCOUNT : scs_pkg::SG_RDATA;
                  end
                  scs_pkg::SG_RCOUNT: begin
                    if (last)
                      hst_reg <= scs_pkg::HS_STOP;
                    else
                      stage_reg <= scs_pkg::SG_RDATA;
                  end
                  scs_pkg::SG_RDATA: begin
                    rd_data  <= sh_reg;
                    rd_valid <= 1'b1;
                    rem_reg  <= rem_reg - 8'h01;
                    if (last)
                      hst_reg <= scs_pkg::HS_STOP;
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // command offset capture
  // ----------------------------------------

  always_ff @(posedge clk) begin
    if (!rstn)
      offset_reg <= 7'h00;
    else if (cmd_ready && cmd_valid)
      offset_reg <= cmd_offset;
  end

  // ----------------------------------------
  // pins, registered from the phase
  // ----------------------------------------
  // sda moves in quarter 0 while scl is low, save the start and stop edges in quarter 2, so no false start or stop
  logic scl_c, pull_c, scl_reg, pull_reg;

  always_comb begin
    scl_c  = 1'b1;
    pull_c = 1'b0;
    unique case (hst_reg)
      scs_pkg::HS_IDLE: begin
      end
      scs_pkg::HS_START: begin
        scl_c  = (q_reg == 2'h1) || (q_reg == 2'h2);
        pull_c = (q_reg >= 2'h2);
      end
      scs_pkg::HS_BIT: begin
        scl_c = (q_reg == 2'h1) || (q_reg == 2'h2);
        if (bitn_reg == 4'h8)
          pull_c = !tx && !last;
        else
          pull_c = tx && !sh_reg[7];
      end
      scs_pkg::HS_STOP: begin
        scl_c  = (q_reg != 2'h0);
        pull_c = (q_reg < 2'h2);
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_reg  <= 1'b1;
      pull_reg <= 1'b0;
    end else begin
      scl_reg  <= scl_c;
      pull_reg <= pull_c;
    end
  end

  assign bus.scl           = scl_reg;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = !pull_reg;

endmodule

// File: hw/scs_if.sv
/*
  Two-wire link between the host end and the device end.
  Assumes the host alone drives the clock wire; the data wire is wired-and.
*/
`timescale 1ns/1ps
interface scs_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // pulled high unless an enabled driver pulls low
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev  (input scl, output dev_sda_o, output dev_sda_oe_n, input sda);
endinterface

// File: hw/scs_params.svh
/*
  Constants of the serial configuration port: address, command fields,
  register image defaults and bit timing.
  Assumes it is included by its bare name before use.
*/
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ----------------------------------------
// addressing and command code
// ----------------------------------------
`define SCS_SLAVE_ADDR    7'h69
`define SCS_CMD_BYTE_BIT  7
`define SCS_BLOCK_OFFSET  7'h00

// ----------------------------------------
// register image
// ----------------------------------------
`define SCS_NBYTES        12
// byte 11 down to byte 0; byte 7 and the id nibble of byte 8 are arbitrary
`define SCS_REG_DEFAULTS  96'h0003_2503_0000_00FF_FFFF_8521
`define SCS_FILL_BYTE     8'h00
`define SCS_OE_BYTE       4
`define SCS_OE1_BIT       6
`define SCS_OE2_BIT       5
`define SCS_OE3_BIT       3
`define SCS_OE4_BIT       2

// ----------------------------------------
// bit timing of the host end
// ----------------------------------------
`define SCS_CLK_NS        40
`define SCS_QUARTER_NS    2500
`define SCS_QUARTER_CYC   ((`SCS_QUARTER_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

`endif

// File: hw/scs_pkg.sv
/*
  Types shared by both ends of the serial configuration port.
  Assumes scs_params.svh holds the numeric constants.
*/
package scs_pkg;

  // nine states need four bits
  typedef enum logic [3:0] {
    DS_IDLE, DS_ADDR, DS_CMD, DS_COUNT, DS_WDATA, DS_SACK, DS_RDATA, DS_HACK, DS_IGNORE
  } scs_dev_st_t;

  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} scs_host_st_t;

  typedef enum logic [2:0] {
    SG_ADDRW, SG_CMD, SG_COUNT, SG_WDATA, SG_ADDRR, SG_RCOUNT, SG_RDATA
  } scs_stage_t;

endpackage
